/* logic/sjb_defines.vh */
// constants for the test-port service bus access block
// assumes inclusion by bare name from the design files under logic/
`ifndef SJB_DEFINES_VH
`define SJB_DEFINES_VH

// ==========================================================
// instruction register
`define SJB_IR_W        5
`define SJB_IR_DEBUG    5'h10
`define SJB_IR_MSVC     5'h14
`define SJB_IR_SIZED    5'h15
`define SJB_IR_BYPASS   5'h1F
`define SJB_IR_FIXED    2'h1

// ==========================================================
// data scan register layout
`define SJB_SR_W        39
`define SJB_TOP_W       6
`define SJB_REG_TOP     6'h21
`define SJB_MEM_TOP     6'h26
`define SJB_BYP_TOP     6'h00
`define SJB_REG_DIR     26
`define SJB_REG_IDX_HI  33
`define SJB_REG_IDX_LO  27
`define SJB_MEM_DIR     0
`define SJB_MEM_SZ_HI   2
`define SJB_MEM_SZ_LO   1
`define SJB_MEM_ADR_HI  38
`define SJB_MEM_ADR_LO  3
`define SJB_ADR_W       36
`define SJB_IDX_W       7
`define SJB_DATA_W      32

// ==========================================================
// access size, direction and target encodings
`define SJB_SZ_BYTE     2'h0
`define SJB_SZ_HALF     2'h1
`define SJB_SZ_WORD     2'h2
`define SJB_DIR_READ    1'b1
`define SJB_TGT_DEBUG   2'h0
`define SJB_TGT_MSVC    2'h1
`define SJB_TGT_MEM     2'h2

`endif

/* logic/sjb_sync2.v */
// two-flop synchroniser for a group of independent level inputs
// assumes each bit is a slow level; no bit-to-bit coherence is kept

// ==========================================================
// synchroniser
module sjb_sync2
#(
  parameter W = 1
)
(
  input  wire         clock,
  input  wire         reset_n,
  input  wire [W-1:0] d,
  output wire [W-1:0] q
);

  reg [W-1:0] meta_reg;
  reg [W-1:0] sync_reg;

  // meta_reg feeds sync_reg and nothing else
  always @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta_reg <= {W{1'b0}};
      sync_reg <= {W{1'b0}};
    end
    else
    begin
      meta_reg <= d;
      sync_reg <= meta_reg;
    end
  end

  assign q = sync_reg;

endmodule // sjb_sync2

/* logic/sjb_access.v */
// test-port access to the service_access_bus: debug registers,
// memory service registers and sized memory accesses
// assumes tck/tms/tdi arrive from pins far slower than clock and a
// service_access_bus slave on clock that answers each request by ack
//
// How it works
// - ir 10000 routes data scans to on_chip_debug registers over the bus
// - register access scan is 34 bits: 7-bit index, direction, 32 data
// - loading an access instruction makes the next data scan an address
// - phase toggles address/data only when a scan captured busy clear
// - direction bit one means read, zero means write
// - capture-ir loads p, error, busy, then fixed 01
// - address and write phases show busy at bit 0, error at bit 1
// - register read phase: 32 data bits low, busy and error above
// - read scans may stop early; device copes with a short scan
// - ir 10100 reaches memory service registers with identical framing
// - ir 10101 does sized accesses: 36-bit address, size, direction
// - size 00 byte, 01 halfword, 10 word, 11 reserved
// - lanes follow address mod 4; halfword at 0/2, word at 0 only
// - sized scan is 39 bits; read data low, busy and error above

`include "sjb_defines.vh"

// ==========================================================
// top
module sjb_access
(
  input  wire        clock,
  input  wire        reset_n,
  input  wire        tck,
  input  wire        tms,
  input  wire        tdi,
  output reg         tdo,
  output reg         tdo_oe,
  input  wire        protect,
  output reg         sab_req,
  output reg         sab_write,
  output reg  [1:0]  sab_target,
  output reg  [35:0] sab_addr,
  output reg  [1:0]  sab_size,
  output reg  [31:0] sab_wdata,
  input  wire        sab_ack,
  input  wire        sab_err,
  input  wire [31:0] sab_rdata,
  output reg         busy_flag,
  output reg         error_flag
);

  // ========================================================
  // test-port controller states
  localparam [3:0] ST_RESET  = 4'h0;
  localparam [3:0] ST_IDLE   = 4'h1;
  localparam [3:0] ST_SEL_DR = 4'h2;
  localparam [3:0] ST_CAP_DR = 4'h3;
  localparam [3:0] ST_SH_DR  = 4'h4;
  localparam [3:0] ST_EX1_DR = 4'h5;
  localparam [3:0] ST_PA_DR  = 4'h6;
  localparam [3:0] ST_EX2_DR = 4'h7;
  localparam [3:0] ST_UPD_DR = 4'h8;
  localparam [3:0] ST_SEL_IR = 4'h9;
  localparam [3:0] ST_CAP_IR = 4'hA;
  localparam [3:0] ST_SH_IR  = 4'hB;
  localparam [3:0] ST_EX1_IR = 4'hC;
  localparam [3:0] ST_PA_IR  = 4'hD;
  localparam [3:0] ST_EX2_IR = 4'hE;
  localparam [3:0] ST_UPD_IR = 4'hF;

  // ========================================================
  // pin sampling and tck edges
  wire tck_s;
  wire tms_s;
  wire tdi_s;
  reg  tck_prev_reg;

  sjb_sync2 #(.W(3)) u_pin_sync
  (
    .clock   (clock),
    .reset_n (reset_n),
    .d       ({tck, tms, tdi}),
    .q       ({tck_s, tms_s, tdi_s})
  );

  wire tck_rise = tck_s & ~tck_prev_reg;
  wire tck_fall = ~tck_s & tck_prev_reg;

  // ========================================================
  // state
  reg [3:0]              tap_reg;
  reg [3:0]              tap_next;
  reg [`SJB_IR_W-1:0]    ir_reg;
  reg [`SJB_IR_W-1:0]    ir_sr_reg;
  reg [`SJB_SR_W-1:0]    sr_reg;
  reg [`SJB_SR_W-1:0]    sr_next;
  reg [`SJB_SR_W-1:0]    cap_val;
  reg                    data_phase_reg;
  reg                    busy_cap_reg;
  reg                    dir_read_reg;
  reg                    addr_ok_reg;
  reg [`SJB_DATA_W-1:0]  rdata_reg;
  reg [`SJB_TOP_W-1:0]   dr_top;
  reg                    size_ok;

  wire is_reg_ir = (ir_reg == `SJB_IR_DEBUG) |
                   (ir_reg == `SJB_IR_MSVC);
  wire is_mem_ir = (ir_reg == `SJB_IR_SIZED);
  wire is_access = is_reg_ir | is_mem_ir;

  wire [1:0]  scan_size = sr_reg[`SJB_MEM_SZ_HI:`SJB_MEM_SZ_LO];
  wire [35:0] scan_addr = sr_reg[`SJB_MEM_ADR_HI:`SJB_MEM_ADR_LO];

  // ========================================================
  // controller next state
  always @*
  begin
    case (tap_reg)
      ST_RESET:  tap_next = tms_s ? ST_RESET  : ST_IDLE;
      ST_IDLE:   tap_next = tms_s ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: tap_next = tms_s ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: tap_next = tms_s ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR:  tap_next = tms_s ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: tap_next = tms_s ? ST_UPD_DR : ST_PA_DR;
      ST_PA_DR:  tap_next = tms_s ? ST_EX2_DR : ST_PA_DR;
      ST_EX2_DR: tap_next = tms_s ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: tap_next = tms_s ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: tap_next = tms_s ? ST_RESET  : ST_CAP_IR;
      ST_CAP_IR: tap_next = tms_s ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR:  tap_next = tms_s ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: tap_next = tms_s ? ST_UPD_IR : ST_PA_IR;
      ST_PA_IR:  tap_next = tms_s ? ST_EX2_IR : ST_PA_IR;
      ST_EX2_IR: tap_next = tms_s ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: tap_next = tms_s ? ST_SEL_DR : ST_IDLE;
      default:   tap_next = ST_RESET;
    endcase
  end

  // ========================================================
  // scan register length, shift and capture
  always @*
  begin
    if (is_mem_ir)
      dr_top = `SJB_MEM_TOP;
    else if (is_reg_ir)
      dr_top = `SJB_REG_TOP;
    else
      dr_top = `SJB_BYP_TOP;
  end

  // bits enter at the top and walk down, so a short register address scan
  // still lands its index and direction in the top bits
  always @*
  begin
    sr_next = sr_reg >> 1;
    sr_next[dr_top] = tdi_s;
  end

  always @*
  begin
    cap_val = {`SJB_SR_W{1'b0}};
    if (is_access)
    begin
      if (data_phase_reg && dir_read_reg)
        cap_val[`SJB_REG_TOP:0] = {error_flag, busy_flag,
                                   rdata_reg};
      else
        cap_val[1:0] = {error_flag, busy_flag};
    end
  end

  // reserved size or misaligned lanes fail without a bus cycle
  always @*
  begin
    case (scan_size)
      `SJB_SZ_BYTE: size_ok = 1'b1;
      `SJB_SZ_HALF: size_ok = ~scan_addr[0];
      `SJB_SZ_WORD: size_ok = (scan_addr[1:0] == 2'h0);
      default:      size_ok = 1'b0;
    endcase
  end

  wire do_upd_dr = tck_rise & (tap_reg == ST_UPD_DR) & is_access;
  wire phase_go  = do_upd_dr & ~busy_cap_reg;
  wire addr_take = phase_go & ~data_phase_reg;
  wire data_take = phase_go & data_phase_reg;
  wire mem_dir   = sr_reg[`SJB_MEM_DIR];
  wire reg_dir   = sr_reg[`SJB_REG_DIR];
  wire new_dir   = is_mem_ir ? mem_dir : reg_dir;
  wire new_ok    = is_mem_ir ? size_ok : 1'b1;
  wire start_rd  = addr_take & new_ok &
                   (new_dir == `SJB_DIR_READ);
  wire start_wr  = data_take & addr_ok_reg & ~dir_read_reg;
  wire bad_size  = addr_take & ~new_ok;
  wire ir_load   = tck_rise & (tap_reg == ST_UPD_IR);
  wire tap_rst   = tck_rise & (tap_reg == ST_RESET);

  // ========================================================
  // test-port side registers
  always @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tck_prev_reg   <= 1'b0;
      tap_reg        <= ST_RESET;
      ir_reg         <= `SJB_IR_BYPASS;
      ir_sr_reg      <= {`SJB_IR_W{1'b0}};
      sr_reg         <= {`SJB_SR_W{1'b0}};
      data_phase_reg <= 1'b0;
      busy_cap_reg   <= 1'b0;
      dir_read_reg   <= 1'b0;
      addr_ok_reg    <= 1'b0;
      tdo            <= 1'b0;
      tdo_oe         <= 1'b0;
    end
    else
    begin
      tck_prev_reg <= tck_s;
      if (tck_rise)
      begin
        tap_reg <= tap_next;
        case (tap_reg)
          ST_RESET:
          begin
            ir_reg         <= `SJB_IR_BYPASS;
            data_phase_reg <= 1'b0;
          end
          ST_CAP_IR:
            ir_sr_reg <= {protect, error_flag, busy_flag,
                          `SJB_IR_FIXED};
          ST_SH_IR:
            ir_sr_reg <= {tdi_s, ir_sr_reg[`SJB_IR_W-1:1]};
          ST_UPD_IR:
          begin
            ir_reg         <= ir_sr_reg;
            data_phase_reg <= 1'b0;
          end
          ST_CAP_DR:
          begin
            sr_reg       <= cap_val;
            busy_cap_reg <= busy_flag;
          end
          ST_SH_DR:
            sr_reg <= sr_next;
          default:
            sr_reg <= sr_reg;
        endcase
        if (phase_go)
          data_phase_reg <= ~data_phase_reg;
        if (addr_take)
        begin
          dir_read_reg <= new_dir;
          addr_ok_reg  <= new_ok;
        end
      end
      if (tck_fall)
      begin
        // drive on the falling edge so the master samples on the rise
        tdo_oe <= (tap_reg == ST_SH_DR) | (tap_reg == ST_SH_IR);
        if (tap_reg == ST_SH_IR)
          tdo <= ir_sr_reg[0];
        else
          tdo <= sr_reg[0];
      end
    end
  end

  // ========================================================
  // service_access_bus side
  always @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sab_req    <= 1'b0;
      sab_write  <= 1'b0;
      sab_target <= `SJB_TGT_DEBUG;
      sab_addr   <= {`SJB_ADR_W{1'b0}};
      sab_size   <= `SJB_SZ_WORD;
      sab_wdata  <= {`SJB_DATA_W{1'b0}};
      rdata_reg  <= {`SJB_DATA_W{1'b0}};
      busy_flag  <= 1'b0;
      error_flag <= 1'b0;
    end
    else
    begin
      if (addr_take)
      begin
        if (is_mem_ir)
        begin
          sab_target <= `SJB_TGT_MEM;
          sab_addr   <= scan_addr;
          sab_size   <= scan_size;
        end
        else
        begin
          sab_target <= (ir_reg == `SJB_IR_MSVC) ?
                        `SJB_TGT_MSVC : `SJB_TGT_DEBUG;
          sab_addr   <= {{(`SJB_ADR_W-`SJB_IDX_W){1'b0}},
                         sr_reg[`SJB_REG_IDX_HI:`SJB_REG_IDX_LO]};
          sab_size   <= `SJB_SZ_WORD;
        end
      end
      if (start_wr)
        sab_wdata <= sr_reg[dr_top -: `SJB_DATA_W];
      if (start_rd || start_wr)
      begin
        sab_req   <= 1'b1;
        sab_write <= start_wr;
        busy_flag <= 1'b1;
      end
      else if (sab_req && sab_ack)
      begin
        sab_req   <= 1'b0;
        busy_flag <= 1'b0;
        if (!sab_write)
          rdata_reg <= sab_rdata;
      end
      // a fault in the same cycle as the clear is kept
      if ((sab_req && sab_ack && sab_err) || bad_size)
        error_flag <= 1'b1;
      else if (ir_load || tap_rst)
        error_flag <= 1'b0;
    end
  end

endmodule // sjb_access

/* testbench/sjb_props.sv */
// checker for the service bus side of sjb_access
// assumes one clock domain and a slave answering with a one-cycle ack
`include "sjb_defines.vh"
// ==========
// bus checks
module sjb_props
(
  input logic        clock,
  input logic        reset_n,
  input logic        sab_req,
  input logic        sab_write,
  input logic [1:0]  sab_target,
  input logic [35:0] sab_addr,
  input logic [1:0]  sab_size,
  input logic [31:0] sab_wdata,
  input logic        sab_ack,
  input logic        sab_err,
  input logic        busy_flag,
  input logic        error_flag
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  sequence s_acked;
    sab_req && sab_ack;
  endsequence
  sequence s_freed;
    !sab_req && !busy_flag;
  endsequence
  req_hold_a: assert property (sab_req && !sab_ack |=> sab_req &&
    $stable({sab_write, sab_target, sab_addr, sab_size, sab_wdata}))
    else $error("bus request changed before ack");
  req_end_a: assert property (s_acked |=> s_freed)
    else $error("request not released after ack");
  busy_rise_a: assert property ($rose(sab_req) |-> $rose(busy_flag))
    else $error("busy not raised with request");
  busy_cover_a: assert property (sab_req |-> busy_flag)
    else $error("request outstanding while not busy");
  err_set_a: assert property (s_acked ##0 sab_err |=> error_flag)
    else $error("bus error not flagged");
  reg_size_a: assert property (sab_req && sab_target !=
    `SJB_TGT_MEM |-> sab_size == `SJB_SZ_WORD && sab_addr[35:7] == 29'h0)
    else $error("register access with bad size or index");
  lane_align_a: assert property (sab_req && sab_target ==
    `SJB_TGT_MEM |-> sab_size != 2'h3 && (sab_size == `SJB_SZ_BYTE ||
    !sab_addr[0] && (sab_size == `SJB_SZ_HALF || !sab_addr[1])))
    else $error("sized access misaligned or reserved");
  target_ok_a: assert property (sab_req |-> sab_target != 2'h3)
    else $error("unknown bus target");
endmodule // sjb_props

bind sjb_access sjb_props u_props
(
  .clock      (clock),
  .reset_n    (reset_n),
  .sab_req    (sab_req),
  .sab_write  (sab_write),
  .sab_target (sab_target),
  .sab_addr   (sab_addr),
  .sab_size   (sab_size),
  .sab_wdata  (sab_wdata),
  .sab_ack    (sab_ack),
  .sab_err    (sab_err),
  .busy_flag  (busy_flag),
  .error_flag (error_flag)
);

/* testbench/sjb_slave.sv */
// service bus slave answering the access block's requests
// assumes requests are held until ack, one outstanding at a time
`include "sjb_defines.vh"
// ==========
// slave
module sjb_slave
(
  input  logic        clock,
  input  logic        reset_n,
  input  logic        slow,
  input  logic        sab_req,
  input  logic [1:0]  sab_target,
  input  logic [35:0] sab_addr,
  input  logic [1:0]  sab_size,
  output logic        sab_ack,
  output logic        sab_err,
  output logic [31:0] sab_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  int wait_cnt;
  always @(posedge clock or negedge reset_n)
    if (!reset_n)
    begin
      wait_cnt  <= 0;
      sab_ack   <= 1'b0;
      sab_err   <= 1'b0;
      sab_rdata <= 32'h0;
    end
    else
    begin
      sab_ack   <= 1'b0;
      // idle data keeps toggling so a stale word is never mistaken
      sab_rdata <= ~sab_rdata;
      if (sab_req && !sab_ack)
        wait_cnt <= wait_cnt + 1;
      if (sab_req && !sab_ack && wait_cnt == (slow ? 30 : 2))
      begin
        wait_cnt  <= 0;
        sab_ack   <= 1'b1;
        // upper half of memory takes word accesses only
        sab_err   <= sab_target == `SJB_TGT_MEM && sab_addr[35] &&
                     sab_size != `SJB_SZ_WORD;
        sab_rdata <= 32'hA5C3_0000 ^ sab_addr[31:0];
      end
    end
endmodule // sjb_slave

/* testbench/tb.sv */
// self-checking bench for sjb_access driven through its test pins
// assumes the slave model and the bound checker beside dut
`include "sjb_defines.vh"
// ==========
// bench
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [4:0]  ir;
    logic        rd;
    logic [1:0]  sz;
    logic [35:0] a;
    logic [31:0] d;
    logic        e;
  } sjb_row_t;
  logic        clock, reset_n, tck, tms, tdi, tdo, tdo_oe, protect, slow;
  logic        sab_req, sab_write, sab_ack, sab_err, busy_flag, error_flag;
  logic        bad, isz, pe, o;
  logic [1:0]  sab_target, sab_size;
  logic [35:0] sab_addr;
  logic [31:0] sab_wdata, sab_rdata, seen_wd;
  logic [38:0] q, din;
  logic [40:0] seen;
  int          failures = 0, checks = 0, nreq = 0, k;
  sjb_row_t    r;
  sjb_row_t    rows [9] = '{
    '{`SJB_IR_DEBUG, 1'b0, 2'h0, 36'h55, 32'h1234_5678, 1'b0},
    '{`SJB_IR_DEBUG, 1'b1, 2'h0, 36'h7F, 32'h0, 1'b0},
    '{`SJB_IR_MSVC, 1'b1, 2'h0, 36'h40, 32'h0, 1'b0},
    '{`SJB_IR_SIZED, 1'b1, 2'h0, 36'h1003, 32'h0, 1'b0},
    '{`SJB_IR_SIZED, 1'b0, 2'h1, 36'h2002, 32'h0000_BEEF, 1'b0},
    '{`SJB_IR_SIZED, 1'b0, 2'h2, 36'h8_0000_0004, 32'hCAFE_F00D, 1'b0},
    '{`SJB_IR_SIZED, 1'b0, 2'h0, 36'h8_0000_0001, 32'h00AB_0000, 1'b1},
    '{`SJB_IR_SIZED, 1'b1, 2'h1, 36'h1, 32'h0, 1'b1},
    '{`SJB_IR_SIZED, 1'b1, 2'h3, 36'h0, 32'h0, 1'b1}
  };

  sjb_access dut
  (
    .clock      (clock),
    .reset_n    (reset_n),
    .tck        (tck),
    .tms        (tms),
    .tdi        (tdi),
    .tdo        (tdo),
    .tdo_oe     (tdo_oe),
    .protect    (protect),
    .sab_req    (sab_req),
    .sab_write  (sab_write),
    .sab_target (sab_target),
    .sab_addr   (sab_addr),
    .sab_size   (sab_size),
    .sab_wdata  (sab_wdata),
    .sab_ack    (sab_ack),
    .sab_err    (sab_err),
    .sab_rdata  (sab_rdata),
    .busy_flag  (busy_flag),
    .error_flag (error_flag)
  );

  sjb_slave slv
  (
    .clock      (clock),
    .reset_n    (reset_n),
    .slow       (slow),
    .sab_req    (sab_req),
    .sab_target (sab_target),
    .sab_addr   (sab_addr),
    .sab_size   (sab_size),
    .sab_ack    (sab_ack),
    .sab_err    (sab_err),
    .sab_rdata  (sab_rdata)
  );

  initial clock = 1'b0;
  always #50 clock = ~clock;

  always @(posedge clock)
    if (sab_req && sab_ack)
    begin
      seen    <= {sab_write, sab_target, sab_addr, sab_size};
      seen_wd <= sab_wdata;
      nreq    <= nreq + 1;
    end

  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    checks++;
    if (s !== e)
    begin
      failures++;
      $display("ERROR %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic end_of_test();
    if (failures == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // low half longer than high so tdo has settled before sampling
  task automatic tk(input logic m, input logic d, output logic so);
    tck = 1'b0;
    tms = m;
    tdi = d;
    repeat (5) @(negedge clock);
    so = tdo;
    tck = 1'b1;
    repeat (3) @(negedge clock);
  endtask

  task automatic scan(input logic ir, input logic [38:0] di, input int n,
                      output logic [38:0] dq);
    logic so;
    dq = 39'h0;
    tk(1'b1, 1'b0, so);
    if (ir)
      tk(1'b1, 1'b0, so);
    tk(1'b0, 1'b0, so);
    tk(1'b0, 1'b0, so);
    for (int i = 0; i < n; i++)
    begin
      tk(i == n - 1, di[i], so);
      dq[i] = so;
      chk(tdo_oe, 1'b1);
    end
    tk(1'b1, 1'b0, so);
    tk(1'b0, 1'b0, so);
    chk(tdo_oe, 1'b0);
  endtask

  task automatic settle();
    repeat (4) @(negedge clock);
    for (int t = 0; t < 200 && busy_flag !== 1'b0; t++)
      @(negedge clock);
  endtask

  initial
  begin
    {reset_n, tck, tms, tdi, protect, slow} = 6'h0;
    pe = 1'b0;
    repeat (10) @(negedge clock);
    reset_n = 1'b1;
    chk({sab_req, busy_flag, error_flag, tdo, tdo_oe, sab_size}, 7'h02);
    tk(1'b0, 1'b0, o);
    for (int i = 0; i < 9; i++)
    begin
      r = rows[i];
      isz = r.ir == `SJB_IR_SIZED;
      bad = isz && (r.sz == 2'h3 || r.sz == 2'h1 && r.a[0] ||
                    r.sz == 2'h2 && r.a[1:0] != 2'h0);
      protect = i[0];
      k = nreq;
      scan(1'b1, {34'h0, r.ir}, 5, q);
      chk(q[4:0], {protect, pe, 3'h1});
      din = isz ? {r.a, r.sz, r.rd} : {5'h0, r.a[6:0], r.rd, 26'h0};
      scan(1'b0, din, isz ? 39 : 34, q);
      chk(q[1:0], 2'h0);
      din = r.rd ? 39'h0 : isz ? {r.d, 7'h0} : {5'h0, r.d, 2'h0};
      scan(1'b0, din, (r.rd || !isz) ? 34 : 39, q);
      settle();
      if (r.rd)
        chk(q[33:32], {r.e, 1'b0});
      else
        chk(q[1:0], 2'h0);
      if (r.rd && !r.e)
        chk(q[31:0], 32'hA5C3_0000 ^ r.a[31:0]);
      chk(nreq - k, bad ? 0 : 1);
      if (!bad)
        chk(seen, {!r.rd, isz ? 2'h2 : {1'b0, r.ir[2]}, r.a,
                   isz ? r.sz : 2'h2});
      if (!bad && !r.rd)
        chk(seen_wd, r.d);
      chk(error_flag, r.e);
      pe = r.e;
    end
    // error is still set from the last row; a controller reset clears it
    repeat (5) tk(1'b1, 1'b0, o);
    tk(1'b0, 1'b0, o);
    slow = 1'b1;
    scan(1'b1, {34'h0, `SJB_IR_DEBUG}, 5, q);
    chk(q[4:0], {protect, 4'h1});
    scan(1'b0, {5'h0, 7'h03, 1'b1, 26'h0}, 34, q);
    scan(1'b0, 39'h0, 34, q);
    chk(q[33:32], 2'h1);
    settle();
    scan(1'b0, 39'h0, 34, q);
    chk(q[33:0], {2'h0, 32'hA5C3_0003});
    end_of_test();
  end

  initial
  begin
    #3_000_000;
    failures++;
    end_of_test();
  end
endmodule // tb
